// ===== pkg/tmr_consts.vh
// register map, field positions, reset values and codes of the timer block
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// register byte addresses
`define TMR_ADDR_CTRL_A   8'hb0
`define TMR_ADDR_CTRL_B   8'hb1
`define TMR_ADDR_COUNT    8'hb2
`define TMR_ADDR_CMP_A    8'hb3
`define TMR_ADDR_CMP_B    8'hb4

// reset values
`define TMR_RST_CTRL_A    8'h00
`define TMR_RST_CTRL_B    8'h00
`define TMR_RST_BYTE      8'h00

// control register a fields
`define TMR_A_OUTMODE_HI  7
`define TMR_A_OUTMODE_LO  6
`define TMR_B_OUTMODE_HI  5
`define TMR_B_OUTMODE_LO  4
`define TMR_WAVE_BIT1     1
`define TMR_WAVE_BIT0     0

// control register b fields
`define TMR_FORCE_A       7
`define TMR_FORCE_B       6
`define TMR_WAVE_BIT2     3
`define TMR_CLKSEL_HI     2
`define TMR_CLKSEL_LO     0

// readable masks
`define TMR_MASK_CTRL_A   8'hf3
`define TMR_MASK_CTRL_B   8'h0f

// counter landmarks
`define TMR_BOTTOM        8'h00
`define TMR_MAX           8'hff

// waveform mode codes
`define TMR_WM_NORMAL     3'h0
`define TMR_WM_PC_FF      3'h1
`define TMR_WM_CLR_MATCH  3'h2
`define TMR_WM_FAST_FF    3'h3
`define TMR_WM_PC_CMP     3'h5
`define TMR_WM_FAST_CMP   3'h7

// output mode codes
`define TMR_OM_OFF        2'h0
`define TMR_OM_TOGGLE     2'h1

// clock select codes and prescaler width
`define TMR_CS_STOP       3'h0
`define TMR_CS_DIV1       3'h1
`define TMR_CS_DIV8       3'h2
`define TMR_CS_DIV32      3'h3
`define TMR_CS_DIV64      3'h4
`define TMR_CS_DIV128     3'h5
`define TMR_CS_DIV256     3'h6
`define TMR_CS_DIV1024    3'h7
`define TMR_PRE_W         10

`endif

// ===== hdl/tmr_prescale.v
// clock prescaler producing the one-cycle timer tick
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"

module tmr_prescale (
    input  wire                 mclk,     // system clock
    input  wire                 sys_rst,  // async reset, active high
    input  wire [2:0]           sel,      // clock select field
    output reg                  tick      // one-cycle timer tick
);

    reg  [`TMR_PRE_W-1:0] div_cnt;   // free running divider
    reg                   next_tick;

    ////////////////////////////////////////////////////////////////////
    // free running divider
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= {`TMR_PRE_W{1'b0}};
        end else begin
            div_cnt <= div_cnt + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // tick chosen by clock select
    always @* begin
        case (sel)                                             // RULE19
            `TMR_CS_STOP:    next_tick = 1'b0;
            `TMR_CS_DIV1:    next_tick = 1'b1;
            `TMR_CS_DIV8:    next_tick = &div_cnt[2:0];
            `TMR_CS_DIV32:   next_tick = &div_cnt[4:0];
            `TMR_CS_DIV64:   next_tick = &div_cnt[5:0];
            `TMR_CS_DIV128:  next_tick = &div_cnt[6:0];
            `TMR_CS_DIV256:  next_tick = &div_cnt[7:0];
            `TMR_CS_DIV1024: next_tick = &div_cnt[9:0];
            default:         next_tick = 1'b0;
        endcase
    end

    // registered tick
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tick <= 1'b0;
        end else begin
            tick <= next_tick;
        end
    end

endmodule // tmr_prescale

`default_nettype wire

// ===== hdl/tmr_wave_ctrl.v
// 8-bit timer with two compare channels and waveform mode control
// Summary of operation
// RULE1: non-pwm a: 00 off, 01 toggle, 10 clear, 11 set
// RULE2: nonzero mode takes pin; driven with direction set; pin a stays on port level in pwm code 01 without wave bit2
// RULE3: fast pwm a: 10 clear match set bottom, 11 inverse
// RULE4: pwm a code 01 toggles only with wave bit2
// RULE5: fast pwm, compare a top, hi bit: act at bottom
// RULE6: phase pwm 10 clear up, set down; 11 opposite
// RULE7: phase pwm, compare top, hi bit: act at top
// RULE8: non-pwm b codes as channel a
// RULE9: fast pwm b: 01 reserved, 10 and 11 as a
// RULE10: phase pwm b: 01 reserved, 10 and 11 as a
// RULE11: wave mode bits: control a 1:0, control b 3
// RULE12: modes 0,1,3 top 0xff; 2,5,7 top compare a
// RULE13: compare update and overflow timing by mode
// RULE14: force a in non-pwm: match per a mode
// RULE15: forced match: no event, counter kept
// RULE16: force a reads zero
// RULE17: software writes force zero in pwm
// RULE18: control registers reset to zero
// RULE19: clock select: stop, 1, 8, 32, 64, 128, 256, 1024
// RULE20: force b like force a for channel b
// RULE21: counter write blocks next tick's match
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"

module tmr_wave_ctrl (
    input  wire       mclk,         // system clock
    input  wire       sys_rst,      // async reset, active high
    input  wire [7:0] io_addr,      // register address
    input  wire       io_wr,        // write strobe
    input  wire       io_rd,        // read strobe
    input  wire [7:0] io_wdata,     // write data
    output reg  [7:0] io_rdata,     // read data, valid after io_rd
    input  wire       dir_a,        // data direction bit of pin a
    input  wire       dir_b,        // data direction bit of pin b
    input  wire       port_a,       // normal port level for pin a
    input  wire       port_b,       // normal port level for pin b
    output reg        pin_a_o,      // pin a output level
    output reg        pin_a_oe,     // pin a output enable
    output reg        pin_b_o,      // pin b output level
    output reg        pin_b_oe,     // pin b output enable
    output reg        match_a_evt,  // compare a match pulse
    output reg        match_b_evt,  // compare b match pulse
    output reg        overflow_evt  // overflow flag set pulse
);

    localparam ST_UP   = 2'b01;     // counting up
    localparam ST_DOWN = 2'b10;     // counting down (phase pwm)

    reg  [7:0] ctrl_a;              // waveform_output_control
    reg  [3:0] ctrl_b;              // wave bit2 and clock select
    reg  [7:0] counter_value;       // timer count
    reg  [7:0] compare_value_a;     // software compare a
    reg  [7:0] compare_value_b;     // software compare b
    reg  [7:0] cmp_a_act;           // compare a in use
    reg  [7:0] cmp_b_act;           // compare b in use
    reg  [1:0] dir_st;              // count direction state
    reg        block_match;         // match blocked until next tick
    reg        compare_out_a;       // waveform level a
    reg        compare_out_b;       // waveform level b

    wire       tick;
    wire [2:0] wave_mode_field;
    wire [1:0] chan_a_output_mode;
    wire [1:0] chan_b_output_mode;
    wire       nonpwm;
    wire       fast;
    wire       phase;
    wire       top_is_cmp;
    wire [7:0] top_val;
    wire       at_top;
    wire       down;
    wire       wr_ctrl_b;
    wire       force_a;
    wire       force_b;
    wire       hit_a;
    wire       hit_b;
    wire       wrap_ev;
    wire       top_ev;
    wire       bot_ev;
    wire       ovf_ev;
    wire       conn_a;
    wire       conn_b;

    reg  [7:0] next_count;
    reg  [1:0] next_dir;
    reg  [7:0] next_rdata;

    ////////////////////////////////////////////////////////////////////
    // next waveform level of one channel
    function oc_next;
        input       cur;
        input [1:0] om;
        input       npwm;
        input       fst;
        input       tgl_ok;
        input       match;
        input       cmp_top;
        input       b_ev;
        input       t_ev;
        input       dn;
        begin
            oc_next = cur;
            if (npwm) begin
                if (match && om == `TMR_OM_TOGGLE)
                    oc_next = ~cur; // RULE1
                else if (match && om[1])
                    oc_next = om[0]; // RULE8
            end else if (om == `TMR_OM_TOGGLE) begin
                if (tgl_ok && match)
                    oc_next = ~cur; // RULE4
            end else if (om[1] && fst) begin
                if (b_ev)
                    oc_next = ~om[0]; // RULE3
                if (match && !cmp_top)
                    oc_next = om[0]; // RULE5
            end else if (om[1]) begin
                if (cmp_top) begin
                    if (t_ev)
                        oc_next = om[0]; // RULE7
                end else if (match) begin
                    oc_next = dn ? ~om[0] : om[0]; // RULE6
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // prescaler
    tmr_prescale u_pre (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .sel     (ctrl_b[`TMR_CLKSEL_HI:`TMR_CLKSEL_LO]),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // mode decode
    assign wave_mode_field = {ctrl_b[`TMR_WAVE_BIT2],
                              ctrl_a[`TMR_WAVE_BIT1:`TMR_WAVE_BIT0]}; // RULE11
    assign chan_a_output_mode = ctrl_a[`TMR_A_OUTMODE_HI:`TMR_A_OUTMODE_LO];
    assign chan_b_output_mode = ctrl_a[`TMR_B_OUTMODE_HI:`TMR_B_OUTMODE_LO];
    assign nonpwm     = ~wave_mode_field[0];
    assign fast       = wave_mode_field == `TMR_WM_FAST_FF ||
                        wave_mode_field == `TMR_WM_FAST_CMP;
    assign phase      = wave_mode_field == `TMR_WM_PC_FF ||
                        wave_mode_field == `TMR_WM_PC_CMP;
    assign top_is_cmp = wave_mode_field == `TMR_WM_CLR_MATCH ||
                        wave_mode_field == `TMR_WM_PC_CMP ||
                        wave_mode_field == `TMR_WM_FAST_CMP;     // RULE12
    assign top_val    = top_is_cmp ? cmp_a_act : `TMR_MAX;       // RULE12
    assign at_top     = counter_value == top_val;
    assign down       = dir_st == ST_DOWN;

    // timer events
    assign wrap_ev = tick && !phase && at_top;
    assign top_ev  = tick && phase && at_top && !down;
    assign bot_ev  = tick && fast && at_top;
    assign ovf_ev  = (wave_mode_field == `TMR_WM_FAST_CMP) ? wrap_ev :
                     phase ? (tick && counter_value == `TMR_BOTTOM) :
                     (tick && counter_value == `TMR_MAX);        // RULE13

    // compare hits, blocked after a counter write
    assign hit_a = tick && !block_match &&
                   counter_value == cmp_a_act; // RULE21
    assign hit_b = tick && !block_match &&
                   counter_value == cmp_b_act; // RULE21

    // force strobes act only in non-pwm modes
    assign wr_ctrl_b = io_wr && io_addr == `TMR_ADDR_CTRL_B;
    assign force_a   = wr_ctrl_b && io_wdata[`TMR_FORCE_A] && nonpwm; // RULE14
    assign force_b   = wr_ctrl_b && io_wdata[`TMR_FORCE_B] && nonpwm; // RULE20

    // pin takeover; pwm code 01 on a stays off unless wave bit2 is set
    assign conn_a = |chan_a_output_mode &&
                    !(!nonpwm && chan_a_output_mode == `TMR_OM_TOGGLE &&
                      !ctrl_b[`TMR_WAVE_BIT2]); // RULE4
    assign conn_b = |chan_b_output_mode; // RULE2

    ////////////////////////////////////////////////////////////////////
    // control and compare registers
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_a          <= `TMR_RST_CTRL_A;                  // RULE18
            ctrl_b          <= 4'h0; // RULE18
            compare_value_a <= `TMR_RST_BYTE;
            compare_value_b <= `TMR_RST_BYTE;
        end else if (io_wr) begin
            case (io_addr)
                `TMR_ADDR_CTRL_A: ctrl_a <= io_wdata & `TMR_MASK_CTRL_A;
                `TMR_ADDR_CTRL_B: ctrl_b <= io_wdata[3:0];       // RULE16
                `TMR_ADDR_CMP_A:  compare_value_a <= io_wdata;
                `TMR_ADDR_CMP_B:  compare_value_b <= io_wdata;
                default:          ctrl_a <= ctrl_a;
            endcase
        end
    end

    // compare values in use: immediate, at top or at bottom
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_a_act <= `TMR_RST_BYTE;
            cmp_b_act <= `TMR_RST_BYTE;
        end else if (nonpwm || (phase && top_ev) ||
                     (fast && bot_ev)) begin                     // RULE13
            cmp_a_act <= compare_value_a;
            cmp_b_act <= compare_value_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counting sequence
    always @* begin
        next_count = counter_value;
        next_dir   = dir_st;
        if (!phase) begin
            next_dir = ST_UP;
            if (tick)
                next_count = at_top ? `TMR_BOTTOM :
                             counter_value + 8'h01;               // RULE15
        end else if (tick) begin
            case (dir_st)
                ST_UP: begin
                    if (at_top) begin
                        next_dir   = ST_DOWN;
                        next_count = counter_value - 8'h01;
                    end else begin
                        next_count = counter_value + 8'h01;
                    end
                end
                ST_DOWN: begin
                    if (counter_value == `TMR_BOTTOM) begin
                        next_dir   = ST_UP;
                        next_count = counter_value + 8'h01;
                    end else begin
                        next_count = counter_value - 8'h01;
                    end
                end
                default: begin
                    next_dir = ST_UP;
                end
            endcase
        end
    end

    // counter, direction and match blocking; software write wins
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            counter_value <= `TMR_RST_BYTE;
            dir_st        <= ST_UP;
            block_match   <= 1'b0;
        end else begin
            dir_st <= next_dir;
            if (io_wr && io_addr == `TMR_ADDR_COUNT) begin
                counter_value <= io_wdata;
                block_match   <= 1'b1;                           // RULE21
            end else begin
                counter_value <= next_count;
                if (tick)
                    block_match <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // waveform levels
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            compare_out_a <= 1'b0;
            compare_out_b <= 1'b0;
        end else begin
            compare_out_a <= oc_next(compare_out_a, chan_a_output_mode,
                                     nonpwm, fast,
                                     ctrl_b[`TMR_WAVE_BIT2],
                                     hit_a || force_a,
                                     cmp_a_act == top_val,
                                     bot_ev, top_ev, down);      // RULE14
            compare_out_b <= oc_next(compare_out_b, chan_b_output_mode,
                                     nonpwm, fast, 1'b0,
                                     hit_b || force_b,
                                     cmp_b_act == top_val,
                                     bot_ev, top_ev, down);      // RULE9 RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin muxing and event pulses
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_a_o      <= 1'b0;
            pin_a_oe     <= 1'b0;
            pin_b_o      <= 1'b0;
            pin_b_oe     <= 1'b0;
            match_a_evt  <= 1'b0;
            match_b_evt  <= 1'b0;
            overflow_evt <= 1'b0;
        end else begin
            pin_a_o  <= conn_a ? compare_out_a : port_a; // RULE2
            pin_b_o  <= conn_b ? compare_out_b : port_b; // RULE2
            pin_a_oe <= dir_a;                                   // RULE2
            pin_b_oe <= dir_b;                                   // RULE2
            // forced matches never reach the event pulses
            match_a_evt  <= hit_a;                               // RULE15
            match_b_evt  <= hit_b;                               // RULE20
            overflow_evt <= ovf_ev;                              // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path; force bits and unused bits read zero
    always @* begin
        case (io_addr)
            `TMR_ADDR_CTRL_A: next_rdata = ctrl_a & `TMR_MASK_CTRL_A;
            `TMR_ADDR_CTRL_B: next_rdata = {4'h0, ctrl_b};       // RULE16
            `TMR_ADDR_COUNT:  next_rdata = counter_value;
            `TMR_ADDR_CMP_A:  next_rdata = compare_value_a;
            `TMR_ADDR_CMP_B:  next_rdata = compare_value_b;
            default:          next_rdata = 8'h00;
        endcase
    end

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            io_rdata <= next_rdata;
        end
    end

endmodule // tmr_wave_ctrl

`default_nettype wire

// ===== test/tmr_wave_ctrl_asserts.sv
// port checker for the timer waveform block
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"

module tmr_wave_chk (
    input wire       mclk,        // clock
    input wire       sys_rst,     // reset
    input wire [7:0] io_addr,     // address
    input wire       io_wr,       // write
    input wire       io_rd,       // read
    input wire [7:0] io_wdata,    // wdata
    input wire [7:0] io_rdata,    // rdata
    input wire       dir_a,       // dir a
    input wire       dir_b,       // dir b
    input wire       port_a,      // port a
    input wire       port_b,      // port b
    input wire       pin_a_o,     // pin a
    input wire       pin_a_oe,    // oe a
    input wire       pin_b_o,     // pin b
    input wire       pin_b_oe,    // oe b
    input wire       match_a_evt, // match a
    input wire       match_b_evt, // match b
    input wire       overflow_evt // overflow
);
    reg [7:0] sh_a;   // mirror of control a
    reg [2:0] sh_cs;  // mirror of clock select

    ////////////////////////////////////////////////////////////////////////
    // mirror of control writes
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_a  <= 8'h00;
            sh_cs <= 3'h0;
        end else if (io_wr && io_addr == `TMR_ADDR_CTRL_A) begin
            sh_a <= io_wdata;
        end else if (io_wr && io_addr == `TMR_ADDR_CTRL_B) begin
            sh_cs <= io_wdata[2:0];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // readback
    AST_RD_CTRL_A: assert property (
        io_wr && io_addr == `TMR_ADDR_CTRL_A ##1 !io_wr && io_rd &&
        io_addr == `TMR_ADDR_CTRL_A |=>
        io_rdata == ($past(io_wdata, 2) & `TMR_MASK_CTRL_A))
        else $error("control a readback wrong");
    AST_RD_CTRL_B: assert property (
        io_wr && io_addr == `TMR_ADDR_CTRL_B ##1 !io_wr && io_rd &&
        io_addr == `TMR_ADDR_CTRL_B |=>
        io_rdata == ($past(io_wdata, 2) & `TMR_MASK_CTRL_B))
        else $error("control b readback wrong");
    AST_UNMAPPED: assert property (
        io_rd && (io_addr < 8'hb0 || io_addr > 8'hb4) |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");

    // pins follow direction and port
    AST_OE_A: assert property (1'b1 |=> pin_a_oe == $past(dir_a))
        else $error("pin a enable wrong");
    AST_OE_B: assert property (1'b1 |=> pin_b_oe == $past(dir_b))
        else $error("pin b enable wrong");
    AST_PORT_A: assert property (
        sh_a[7:6] == 2'b00 |=> pin_a_o == $past(port_a))
        else $error("pin a not port level");
    AST_PORT_B: assert property (
        sh_a[5:4] == 2'b00 |=> pin_b_o == $past(port_b))
        else $error("pin b not port level");

    // no events while stopped
    AST_STOPPED: assert property (
        (sh_cs == 3'h0) [*4] |->
        !match_a_evt && !match_b_evt && !overflow_evt)
        else $error("event while stopped");

    COV_MATCH_A: cover property (match_a_evt);
    COV_MATCH_B: cover property (match_b_evt);
    COV_OVF: cover property (overflow_evt);
endmodule // tmr_wave_chk

bind tmr_wave_ctrl tmr_wave_chk tmr_wave_chk_inst (.*);
`default_nettype wire

// ===== test/tmr_wave_ctrl_bench.sv
// self-checking bench for the timer waveform block
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"

module tmr_wave_ctrl_bench;
    typedef struct {string nm; logic [3:0] s; logic [15:0] e;} tmr_note_t;
    logic        mclk, sys_rst, io_wr, io_rd, dir_a, dir_b, port_a, port_b;
    logic [7:0]  io_addr, io_wdata, d;
    wire  [7:0]  io_rdata;
    wire         pin_a_o, pin_a_oe, pin_b_o, pin_b_oe;
    wire         match_a_evt, match_b_evt, overflow_evt;
    logic        obs, mark, look;
    logic [15:0] cyc, ev_a, ev_b, gap_a, gap_o, last_a, last_o, hi_a, hi_b;
    logic [15:0] v, ea;
    int          err_total, total_checks, i;
    int          dvt [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0]  fa [4] = '{8'hf0, 8'ha0, 8'h50, 8'h50};
    logic [2:0]  mt [6] = '{3'd0, 3'd3, 3'd1, 3'd2, 3'd5, 3'd7};
    int          gt [6] = '{256, 256, 510, 4, 6, 4};
    tmr_note_t   q [$];
    tmr_note_t   n;

    tmr_wave_ctrl tmr_wave_ctrl_inst (.*);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // event counts, gaps, high time
    always @(posedge mclk) begin
        cyc  <= cyc + 16'h0001;
        look <= io_rd | obs;
        if (match_a_evt === 1'b1) begin
            ev_a   <= ev_a + 16'h0001;
            gap_a  <= cyc - last_a;
            last_a <= cyc;
        end
        if (match_b_evt === 1'b1) begin
            ev_b <= ev_b + 16'h0001;
        end
        if (overflow_evt === 1'b1) begin
            gap_o  <= cyc - last_o;
            last_o <= cyc;
        end
        hi_a <= mark ? 16'h0000 : hi_a + 16'(pin_a_o);
        hi_b <= mark ? 16'h0000 : hi_b + 16'(pin_b_o);
    end

    // compare oldest notes
    always @(negedge mclk) begin
        if (look === 1'b1) begin
            while (q.size() > 0) begin
                n = q.pop_front();
                case (n.s)
                    4'd0:    v = {8'h00, io_rdata};
                    4'd1:    v = 16'(pin_a_o);
                    4'd2:    v = 16'(pin_b_o);
                    4'd3:    v = 16'(pin_a_oe);
                    4'd4:    v = 16'(pin_b_oe);
                    4'd5:    v = ev_a;
                    4'd7:    v = gap_a;
                    4'd8:    v = gap_o;
                    4'd9:    v = hi_a;
                    4'd10:   v = hi_b;
                    default: v = ev_b;
                endcase
                total_checks++;
                if (v !== n.e) begin
                    err_total++;
                    $display("[FAIL] %s exp %h seen %h", n.nm, n.e, v);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus and observation tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge mclk);
        io_addr  <= a;
        io_wdata <= dat;
        io_wr    <= 1'b1;
        @(posedge mclk);
        io_wr <= 1'b0;
    endtask

    task automatic see(input string nm, input logic [3:0] s,
                       input logic [15:0] e);
        q.push_back('{nm, s, e});
    endtask

    task automatic fire;
        @(posedge mclk);
        obs <= 1'b1;
        @(posedge mclk);
        obs <= 1'b0;
    endtask

    // read, then write and read back
    task automatic rd(input logic [7:0] a, e);
        @(posedge mclk);
        io_addr <= a;
        io_rd   <= 1'b1;
        see("io_rdata", 4'd0, {8'h00, e});
        @(posedge mclk);
        io_rd <= 1'b0;
    endtask

    task automatic wrrd(input logic [7:0] a, dat, e);
        wr(a, dat);
        rd(a, e);
    endtask

    // pwm run, then high time over one window
    task automatic pwm(input logic [2:0] m, input logic [7:0] ca, oa, ob,
                       input int per, input logic [15:0] xa, xb);
        wr(`TMR_ADDR_CTRL_B, 8'h00);
        wr(`TMR_ADDR_CTRL_A, 8'h00);
        wr(`TMR_ADDR_CMP_A, oa);
        wr(`TMR_ADDR_CMP_B, ob);
        wr(`TMR_ADDR_COUNT, 8'h00);
        wr(`TMR_ADDR_CTRL_A, {ca[7:4], 2'b00, m[1:0]});
        wr(`TMR_ADDR_CTRL_B, {4'h0, m[2], 3'h1});
        repeat (per + 8) @(posedge mclk);
        mark <= 1'b1;
        @(posedge mclk);
        mark <= 1'b0;
        repeat (per - 2) @(posedge mclk);
        see("hi_a", 4'd9, xa);
        see("hi_b", 4'd10, xb);
        fire;
    endtask

    task automatic end_of_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {io_addr, io_wdata, io_wr, io_rd, obs, mark, look} = '0;
        {dir_a, dir_b, port_a, port_b, err_total, total_checks} = '0;
        {cyc, ev_a, ev_b, gap_a, gap_o, last_a, last_o, hi_a, hi_b} = '0;
        sys_rst = 1'b1;
        d = 8'($urandom(32'h3dd14f40));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        wrrd(`TMR_ADDR_CTRL_A, `TMR_RST_CTRL_A, 8'h00);
        wrrd(8'hb5, 8'hff, 8'h00);
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wrrd(`TMR_ADDR_CTRL_A, d, d & `TMR_MASK_CTRL_A);
            wrrd(`TMR_ADDR_CTRL_B, d & (d[0] ? 8'h08 : 8'hc8),
                 d & 8'h08);
        end
        wr(`TMR_ADDR_CTRL_A, 8'h00);
        for (i = 0; i < 4; i++) begin
            {dir_a, dir_b, port_a, port_b} <= 4'($urandom);
            repeat (3) @(posedge mclk);
            see("pin_a_o", 4'd1, 16'(port_a));
            see("pin_b_o", 4'd2, 16'(port_b));
            see("pin_a_oe", 4'd3, 16'(dir_a));
            see("pin_b_oe", 4'd4, 16'(dir_b));
            fire;
        end
        wr(`TMR_ADDR_CTRL_B, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(`TMR_ADDR_CTRL_A, fa[i]);
            wr(`TMR_ADDR_CTRL_B, 8'hc0);
            repeat (3) @(posedge mclk);
            see("pin_a_o", 4'd1, 16'(~i & 1));
            see("pin_b_o", 4'd2, 16'(~i & 1));
            fire;
        end
        see("ev_a", 4'd5, 16'h0000);
        see("ev_b", 4'd11, 16'h0000);
        wr(`TMR_ADDR_CTRL_A, 8'h52);
        wr(`TMR_ADDR_COUNT, 8'h37);
        wrrd(`TMR_ADDR_CTRL_B, 8'hc0, 8'h00);
        wr(`TMR_ADDR_COUNT - 8'h01, 8'h00);
        rd(`TMR_ADDR_COUNT, 8'h37);
        wr(`TMR_ADDR_CTRL_A, 8'ha0);
        wr(`TMR_ADDR_CTRL_B, 8'hc0);
        wr(`TMR_ADDR_CTRL_A, 8'hf3);
        wr(`TMR_ADDR_CTRL_B, 8'hc0);
        repeat (3) @(posedge mclk);
        see("pin_a_o", 4'd1, 16'h0000);
        see("pin_b_o", 4'd2, 16'h0000);
        fire;
        wr(`TMR_ADDR_CTRL_A, 8'h00);
        wr(`TMR_ADDR_CTRL_B, 8'h00);
        wr(`TMR_ADDR_CMP_A, 8'hfe);
        ea = 16'h0000;
        for (i = 1; i < 8; i++) begin
            wr(`TMR_ADDR_COUNT, 8'hfd);
            wr(`TMR_ADDR_CTRL_B, 8'(i));
            repeat (dvt[i] / 2) @(posedge mclk);
            if (dvt[i] >= 8) see("ev_a", 4'd5, ea);
            fire;
            repeat (2 * dvt[i]) @(posedge mclk);
            wr(`TMR_ADDR_CTRL_B, 8'h00);
            ea = ea + 16'h0001;
            repeat (4) @(posedge mclk);
            see("ev_a", 4'd5, ea);
            fire;
        end
        wr(`TMR_ADDR_CMP_A, 8'h40);
        wr(`TMR_ADDR_COUNT, 8'h40);
        wr(`TMR_ADDR_CTRL_B, 8'h01);
        repeat (6) @(posedge mclk);
        wr(`TMR_ADDR_CTRL_B, 8'h00);
        repeat (4) @(posedge mclk);
        see("ev_a", 4'd5, ea);
        fire;
        wr(`TMR_ADDR_CMP_A, 8'h03);
        for (i = 0; i < 6; i++) begin
            wr(`TMR_ADDR_CTRL_B, 8'h00);
            wr(`TMR_ADDR_COUNT, 8'h00);
            wr(`TMR_ADDR_CTRL_A, {6'h00, mt[i][1:0]});
            wr(`TMR_ADDR_CTRL_B, {4'h0, mt[i][2], 3'h1});
            repeat (2 * gt[i] + 20) @(posedge mclk);
            see("gap", (i == 3) ? 4'd7 : 4'd8, 16'(gt[i]));
            fire;
        end
        {port_a, port_b} <= 2'b11;
        pwm(3'd3, 8'hb0, 8'h40, 8'h80, 256, 16'd65, 16'd127);
        pwm(3'd1, 8'hb0, 8'h40, 8'h80, 510, 16'd128, 16'd254);
        pwm(3'd3, 8'h80, 8'hff, 8'h00, 256, 16'd256, 16'd256);
        pwm(3'd1, 8'h80, 8'hff, 8'h00, 510, 16'd0, 16'd510);
        pwm(3'd1, 8'h40, 8'h00, 8'h00, 510, 16'd510, 16'd510);
        pwm(3'd5, 8'h40, 8'h40, 8'h00, 256, 16'd128, 16'd256);
        repeat (4) @(posedge mclk);
        end_of_test();
    end
endmodule // tmr_wave_ctrl_bench
`default_nettype wire
